// ---- design/pfm_monitor.sv ----
// Purpose: permanent failure monitor with register port and interrupt
// Assumes: measurements are synchronous to ref_clk and refreshed before each tick
// Notes: read data appear the cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
module pfm_monitor
    import pfm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire pfm_meas_type meas,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic stack_mismatch_fail_flag,
    output logic charge_overcurrent_fail,
    output logic discharge_overcurrent_fail,
    output logic cell_overtemp_fail,
    output logic fet_overtemp_fail,
    output logic imbalance_at_rest_fail
);
    logic tick;
    logic [5:0] chk_en;
    logic [4:0] cell_count;
    logic [15:0] stack_thr;
    logic [15:0] sleep_cur;
    logic [15:0] chg_thr;
    logic [15:0] dsg_thr;
    logic [7:0] cell_ot_thr;
    logic [7:0] fet_ot_thr;
    logic [7:0] dly [NCHK];
    logic [15:0] check_mv;
    logic [15:0] relax_cur;
    logic [15:0] imb_thr;
    logic [15:0] relax_dur;
    logic [15:0] relax_cnt;
    logic [5:0] int_stat;
    logic [5:0] int_en;
    logic [NCHK-1:0] cond;
    logic [NCHK-1:0] fail;
    logic [NCHK-1:0] fail_set;
    logic [7:0] cnt [NCHK];

    pfm_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick)
    );

    // register write decode
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_cells = reg_wr && (reg_addr == ADDR_CELLS);
    wire wr_stack_thr = reg_wr && (reg_addr == ADDR_STACK_THR);
    wire wr_sleep_cur = reg_wr && (reg_addr == ADDR_SLEEP_CUR);
    wire wr_chg_thr = reg_wr && (reg_addr == ADDR_CHG_THR);
    wire wr_dsg_thr = reg_wr && (reg_addr == ADDR_DSG_THR);
    wire wr_temp_thr = reg_wr && (reg_addr == ADDR_TEMP_THR);
    wire wr_delay_a = reg_wr && (reg_addr == ADDR_DELAY_A);
    wire wr_delay_b = reg_wr && (reg_addr == ADDR_DELAY_B);
    wire wr_check_mv = reg_wr && (reg_addr == ADDR_CHECK_MV);
    wire wr_relax_cur = reg_wr && (reg_addr == ADDR_RELAX_CUR);
    wire wr_imb_thr = reg_wr && (reg_addr == ADDR_IMB_THR);
    wire wr_relax_dur = reg_wr && (reg_addr == ADDR_RELAX_DUR);
    wire wr_int_clr = reg_wr && (reg_addr == ADDR_INT_CLR);
    wire wr_int_en = reg_wr && (reg_addr == ADDR_INT_EN);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chk_en <= RST_CTRL;
            cell_count <= RST_CELLS;
            stack_thr <= RST_STACK_THR;
            sleep_cur <= RST_SLEEP_CUR;
            chg_thr <= RST_CHG_THR;
            dsg_thr <= RST_DSG_THR;
            cell_ot_thr <= RST_CELL_OT;
            fet_ot_thr <= RST_FET_OT;
            check_mv <= RST_CHECK_MV;
            relax_cur <= RST_RELAX_CUR;
            imb_thr <= RST_IMB_THR;
            relax_dur <= RST_RELAX_DUR;
            int_en <= 6'h00;
        end else begin
            if (wr_ctrl) chk_en <= reg_wdata[5:0];
            if (wr_cells) cell_count <= reg_wdata[4:0];
            if (wr_stack_thr) stack_thr <= reg_wdata[15:0];
            if (wr_sleep_cur) sleep_cur <= reg_wdata[15:0];
            if (wr_chg_thr) chg_thr <= reg_wdata[15:0];
            if (wr_dsg_thr) dsg_thr <= reg_wdata[15:0];
            if (wr_temp_thr) begin
                cell_ot_thr <= reg_wdata[7:0];
                fet_ot_thr <= reg_wdata[15:8];
            end
            if (wr_check_mv) check_mv <= reg_wdata[15:0];
            if (wr_relax_cur) relax_cur <= reg_wdata[15:0];
            if (wr_imb_thr) imb_thr <= reg_wdata[15:0];
            if (wr_relax_dur) relax_dur <= reg_wdata[15:0];
            if (wr_int_en) int_en <= reg_wdata[5:0];
        end
    end

    // delays: charge, discharge, cell temp, fet temp in one word; stack, imbalance in another
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NCHK; i++) begin
                dly[i] <= RST_DELAY;
            end
        end else begin
            if (wr_delay_a) begin
                dly[IDX_CHG_OC] <= reg_wdata[7:0];
                dly[IDX_DSG_OC] <= reg_wdata[15:8];
                dly[IDX_CELL_OT] <= reg_wdata[23:16];
                dly[IDX_FET_OT] <= reg_wdata[31:24];
            end
            if (wr_delay_b) begin
                dly[IDX_STACK] <= reg_wdata[7:0];
                dly[IDX_IMB] <= reg_wdata[15:8];
            end
        end
    end

    // stack versus cell sum
    wire [19:0] stack_diff = (meas.stack_mv >= meas.cell_sum_mv) ? meas.stack_mv - meas.cell_sum_mv
                                                                 : meas.cell_sum_mv - meas.stack_mv;
    wire [20:0] stack_limit = 21'(stack_thr) * 21'(cell_count);
    // load steps between samples make the two sums disagree, so skip under current
    wire stack_skip = meas.meas_abs_current > sleep_cur;
    assign cond[IDX_STACK] = chk_en[IDX_STACK] & ~stack_skip & ({1'b0, stack_diff} >= stack_limit);

    // overcurrent and overtemperature
    assign cond[IDX_CHG_OC] = chk_en[IDX_CHG_OC] & ($signed(meas.current) >= $signed(chg_thr));
    assign cond[IDX_DSG_OC] = chk_en[IDX_DSG_OC] & ($signed(meas.current) >= $signed(dsg_thr));
    assign cond[IDX_CELL_OT] = chk_en[IDX_CELL_OT] & ($signed(meas.max_cell_temp) >= $signed(cell_ot_thr));
    assign cond[IDX_FET_OT] = chk_en[IDX_FET_OT] & (meas.fet_temp >= fet_ot_thr);

    // imbalance at rest
    // one extra bit so full-scale negative current stays positive
    wire [16:0] cur_ext = {meas.current[15], meas.current};
    wire [16:0] abs_cur = cur_ext[16] ? (~cur_ext + 17'h00001) : cur_ext;
    wire rest_volt_ok = meas.max_cell_mv >= check_mv;
    wire rest_cur_ok = abs_cur < {1'b0, relax_cur};
    wire rest_cond = chk_en[IDX_IMB] & rest_volt_ok & rest_cur_ok;
    wire rest_qual = rest_cond & (relax_cnt >= relax_dur);
    wire [15:0] imb_delta = (meas.max_cell_mv >= meas.min_cell_mv) ? meas.max_cell_mv - meas.min_cell_mv
                                                                   : 16'h0000;
    assign cond[IDX_IMB] = rest_qual & (imb_delta >= imb_thr);
    wire [15:0] next_relax_cnt = !tick ? relax_cnt
                                : (!rest_cond ? 16'h0000 : (relax_cnt == RELAX_MAX ? relax_cnt : relax_cnt + 16'h0001));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            relax_cnt <= 16'h0000;
        end else begin
            relax_cnt <= next_relax_cnt;
        end
    end

    // one persistence stage per check; delays come from dly
    for (genvar g = 0; g < NCHK; g++) begin : g_chk
        pfm_persist u_persist (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .tick(tick),
            .cond(cond[g]),
            .delay(dly[g]),
            .count(cnt[g]),
            .fail(fail[g]),
            .fail_set(fail_set[g])
        );
    end

    assign stack_mismatch_fail_flag = fail[IDX_STACK];
    assign charge_overcurrent_fail = fail[IDX_CHG_OC];
    assign discharge_overcurrent_fail = fail[IDX_DSG_OC];
    assign cell_overtemp_fail = fail[IDX_CELL_OT];
    assign fet_overtemp_fail = fail[IDX_FET_OT];
    assign imbalance_at_rest_fail = fail[IDX_IMB];

    // interrupt status: a new failure wins over a same-cycle clear
    wire [5:0] int_clr_mask = wr_int_clr ? reg_wdata[5:0] : 6'h00;
    wire [5:0] next_int_stat = (int_stat & ~int_clr_mask) | fail_set;
    assign irq = |(int_stat & int_en);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_stat <= 6'h00;
        end else begin
            int_stat <= next_int_stat;
        end
    end

    // read selection; unmapped and write-only addresses read zero
    wire [31:0] rd_mux =
        (reg_addr == ADDR_CTRL) ? {26'h0, chk_en} :
        (reg_addr == ADDR_CELLS) ? {27'h0, cell_count} :
        (reg_addr == ADDR_STACK_THR) ? {16'h0, stack_thr} :
        (reg_addr == ADDR_SLEEP_CUR) ? {16'h0, sleep_cur} :
        (reg_addr == ADDR_CHG_THR) ? {16'h0, chg_thr} :
        (reg_addr == ADDR_DSG_THR) ? {16'h0, dsg_thr} :
        (reg_addr == ADDR_TEMP_THR) ? {16'h0, fet_ot_thr, cell_ot_thr} :
        (reg_addr == ADDR_DELAY_A) ? {dly[IDX_FET_OT], dly[IDX_CELL_OT], dly[IDX_DSG_OC], dly[IDX_CHG_OC]} :
        (reg_addr == ADDR_DELAY_B) ? {16'h0, dly[IDX_IMB], dly[IDX_STACK]} :
        (reg_addr == ADDR_CHECK_MV) ? {16'h0, check_mv} :
        (reg_addr == ADDR_RELAX_CUR) ? {16'h0, relax_cur} :
        (reg_addr == ADDR_IMB_THR) ? {16'h0, imb_thr} :
        (reg_addr == ADDR_RELAX_DUR) ? {16'h0, relax_dur} :
        (reg_addr == ADDR_FAIL) ? {26'h0, fail} :
        (reg_addr == ADDR_INT_STAT) ? {26'h0, int_stat} :
        (reg_addr == ADDR_INT_EN) ? {26'h0, int_en} :
        (reg_addr == ADDR_RELAX_CNT) ? {16'h0, relax_cnt} : 32'h0;
    wire [31:0] next_rdata = reg_rd ? rd_mux : 32'h0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // failures and stack check
    chk_fail_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 ((fail & $past(fail)) == $past(fail)))
        else $error("failure flag dropped before reset");

    chk_stack_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && chk_en[IDX_STACK] && !stack_skip && ({1'b0, stack_diff} >= 21'(stack_thr) * 21'(cell_count)))
        |=> (cnt[IDX_STACK] != 8'h00))
        else $error("stack mismatch not counted");

    chk_stack_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && meas.meas_abs_current > sleep_cur) |=> (cnt[IDX_STACK] == 8'h00))
        else $error("stack check not skipped under current");

    chk_stack_disabled: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && !chk_en[IDX_STACK]) |=> (cnt[IDX_STACK] == 8'h00))
        else $error("disabled stack check still counting");

    chk_stack_fail_time: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && cond[IDX_STACK] && ({1'b0, cnt[IDX_STACK]} + 9'h001 >= {1'b0, dly[IDX_STACK]}))
        |=> stack_mismatch_fail_flag)
        else $error("stack mismatch failure late");

    // overcurrent and overtemperature
    chk_chg_below: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && $signed(meas.current) < $signed(chg_thr)) |=> (cnt[IDX_CHG_OC] == 8'h00))
        else $error("charge overcurrent counted below threshold");

    chk_dsg_below: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && $signed(meas.current) < $signed(dsg_thr)) |=> (cnt[IDX_DSG_OC] == 8'h00))
        else $error("discharge overcurrent counted below threshold");

    chk_dsg_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && chk_en[IDX_DSG_OC] && $signed(meas.current) >= $signed(dsg_thr)
         && cnt[IDX_DSG_OC] != CNT_MAX) |=> (cnt[IDX_DSG_OC] == $past(cnt[IDX_DSG_OC]) + 8'h01))
        else $error("discharge overcurrent not counted");

    chk_cell_ot_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && chk_en[IDX_CELL_OT] && $signed(meas.max_cell_temp) >= $signed(cell_ot_thr)
         && cnt[IDX_CELL_OT] != CNT_MAX) |=> (cnt[IDX_CELL_OT] == $past(cnt[IDX_CELL_OT]) + 8'h01))
        else $error("cell overtemperature not counted");

    chk_fet_ot_below: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && meas.fet_temp < fet_ot_thr) |=> (cnt[IDX_FET_OT] == 8'h00))
        else $error("fet overtemperature counted below threshold");

    // rest qualification and imbalance
    chk_rest_volt: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && meas.max_cell_mv < check_mv) |=> (relax_cnt == 16'h0000 && cnt[IDX_IMB] == 8'h00))
        else $error("imbalance evaluated below check voltage");

    chk_rest_current: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && abs_cur >= {1'b0, relax_cur}) |=> (relax_cnt == 16'h0000 && cnt[IDX_IMB] == 8'h00))
        else $error("imbalance evaluated under current");

    chk_rest_qualify: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && relax_cnt < relax_dur) |=> (cnt[IDX_IMB] == 8'h00))
        else $error("imbalance counted before relax duration");

    chk_relax_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && !rest_cond) |=> (relax_cnt == 16'h0000))
        else $error("relax counter not cleared");

    chk_relax_step: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && rest_cond && relax_cnt != RELAX_MAX) |=> (relax_cnt == $past(relax_cnt) + 16'h0001))
        else $error("relax counter did not advance");

    chk_relax_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !tick |=> $stable(relax_cnt))
        else $error("relax counter moved without tick");

    chk_imb_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && rest_qual && imb_delta >= imb_thr && cnt[IDX_IMB] == 8'h00) |=> (cnt[IDX_IMB] == 8'h01))
        else $error("imbalance not counted when qualified");

    // interrupt and register port
    chk_int_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fail_set != 6'h00) |=> ((int_stat & $past(fail_set)) == $past(fail_set)))
        else $error("interrupt status missed a failure");

    // a clear only drops bits that no failure sets in that cycle
    chk_int_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_int_clr && ((fail_set & reg_wdata[5:0]) == 6'h00)) |=> ((int_stat & $past(reg_wdata[5:0])) == 6'h00))
        else $error("interrupt status not cleared");

    // read data are zero outside the answer cycle, so an or-tree of slaves is safe
    chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        !reg_rd |=> (reg_rdata == 32'h0))
        else $error("read data not zero outside a read");

    chk_rdata_fail: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == ADDR_FAIL) |=> (reg_rdata == {26'h0, $past(fail)}))
        else $error("failure flags read back wrong");

    chk_rdata_stat: assert property (@(posedge ref_clk) disable iff (!nrst)
        (reg_rd && reg_addr == ADDR_INT_STAT) |=> (reg_rdata == {26'h0, $past(int_stat)}))
        else $error("interrupt status read back wrong");

    // main scenarios
    cov_stack_fail: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(stack_mismatch_fail_flag));
    cov_dsg_fail: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(discharge_overcurrent_fail));
    cov_imb_fail: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(imbalance_at_rest_fail));
    cov_rest_qual: cover property (@(posedge ref_clk) disable iff (!nrst) tick && rest_qual);
    cov_irq: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));
endmodule

// ---- design/pfm_pkg.sv ----
// Purpose: shared constants and types for the permanent failure monitor
// Assumes: 50 MHz ref_clk, one-second evaluation tick
// Notes: register byte addresses are word aligned
package pfm_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_S * CLK_HZ;

    localparam int NCHK = 6;
    localparam int IDX_STACK = 0;
    localparam int IDX_CHG_OC = 1;
    localparam int IDX_DSG_OC = 2;
    localparam int IDX_CELL_OT = 3;
    localparam int IDX_FET_OT = 4;
    localparam int IDX_IMB = 5;

    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [15:0] RELAX_MAX = 16'hffff;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CELLS = 8'h04;
    localparam logic [7:0] ADDR_STACK_THR = 8'h08;
    localparam logic [7:0] ADDR_SLEEP_CUR = 8'h0c;
    localparam logic [7:0] ADDR_CHG_THR = 8'h10;
    localparam logic [7:0] ADDR_DSG_THR = 8'h14;
    localparam logic [7:0] ADDR_TEMP_THR = 8'h18;
    localparam logic [7:0] ADDR_DELAY_A = 8'h1c;
    localparam logic [7:0] ADDR_DELAY_B = 8'h20;
    localparam logic [7:0] ADDR_CHECK_MV = 8'h24;
    localparam logic [7:0] ADDR_RELAX_CUR = 8'h28;
    localparam logic [7:0] ADDR_IMB_THR = 8'h2c;
    localparam logic [7:0] ADDR_RELAX_DUR = 8'h30;
    localparam logic [7:0] ADDR_FAIL = 8'h34;
    localparam logic [7:0] ADDR_INT_STAT = 8'h38;
    localparam logic [7:0] ADDR_INT_CLR = 8'h3c;
    localparam logic [7:0] ADDR_INT_EN = 8'h40;
    localparam logic [7:0] ADDR_RELAX_CNT = 8'h44;

    localparam logic [5:0] RST_CTRL = 6'h3f;
    localparam logic [4:0] RST_CELLS = 5'h10;
    localparam logic [15:0] RST_STACK_THR = 16'h01f4;
    localparam logic [15:0] RST_SLEEP_CUR = 16'h0014;
    localparam logic [15:0] RST_CHG_THR = 16'h2710;
    localparam logic [15:0] RST_DSG_THR = 16'h8300;
    localparam logic [7:0] RST_CELL_OT = 8'h41;
    localparam logic [7:0] RST_FET_OT = 8'h55;
    localparam logic [7:0] RST_DELAY = 8'h05;
    localparam logic [15:0] RST_CHECK_MV = 16'h0dac;
    localparam logic [15:0] RST_RELAX_CUR = 16'h000a;
    localparam logic [15:0] RST_IMB_THR = 16'h01f4;
    localparam logic [15:0] RST_RELAX_DUR = 16'h0064;

    typedef struct packed {
        logic [19:0] stack_mv;
        logic [19:0] cell_sum_mv;
        logic [15:0] max_cell_mv;
        logic [15:0] min_cell_mv;
        logic [15:0] current;
        logic [15:0] meas_abs_current;
        logic [7:0] max_cell_temp;
        logic [7:0] fet_temp;
    } pfm_meas_type;
endpackage

// ---- design/pfm_tick.sv ----
// Purpose: one-second evaluation tick from ref_clk
// Assumes: TICK_CYCLES at least 2
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
module pfm_tick
    import pfm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    output logic tick
);
    logic [31:0] div_cnt;
    wire div_wrap = (div_cnt == 32'(TICK_CYCLES - 1));
    wire [31:0] next_div_cnt = div_wrap ? 32'h0 : div_cnt + 32'h1;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= div_wrap;
        end
    end
endmodule

// ---- design/pfm_persist.sv ----
// Purpose: persistence counter and latched failure for one check
// Assumes: tick is a one-cycle pulse
// Notes: delay 0 and 1 both trip on the first qualifying tick
`timescale 1ns/1ps
module pfm_persist
    import pfm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic cond,
    input wire logic [7:0] delay,
    output logic [7:0] count,
    output logic fail,
    output logic fail_set
);
    wire [8:0] next_run = {1'b0, count} + 9'h001;
    wire hit = tick & cond & (next_run >= {1'b0, delay});
    // saturate so a long condition never wraps back below delay
    wire [7:0] next_count = !tick ? count : (!cond ? 8'h00 : (count == CNT_MAX ? count : next_run[7:0]));
    wire next_fail = fail | hit;

    assign fail_set = hit & ~fail;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count <= 8'h00;
            fail <= 1'b0;
        end else begin
            count <= next_count;
            fail <= next_fail;
        end
    end

    chk_count_advance: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && cond && count != CNT_MAX) |=> (count == $past(count) + 8'h01))
        else $error("persistence count did not advance");
    chk_count_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && !cond) |=> (count == 8'h00))
        else $error("persistence count not cleared");
    chk_count_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !tick |=> $stable(count))
        else $error("persistence count moved without tick");
    chk_fail_timing: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && cond && ({1'b0, count} + 9'h001 >= {1'b0, delay})) |=> fail)
        else $error("failure not raised after delay");
    chk_fail_early: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!fail && !(tick && cond && ({1'b0, count} + 9'h001 >= {1'b0, delay}))) |=> !fail)
        else $error("failure raised before delay");
endmodule

// ---- verification/pfm_meas_src.sv ----
// Purpose: measurement subsystem stand-in feeding the monitor
// Assumes: bench changes raw levels just after a rising edge
// Notes: abs current is derived here, as the front end reports it
`timescale 1ns/1ps
module pfm_meas_src
    import pfm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [19:0] stk,
    input wire logic [19:0] csum,
    input wire logic [15:0] vmax,
    input wire logic [15:0] vmin,
    input wire logic [15:0] cur,
    input wire logic [7:0] tcell,
    input wire logic [7:0] tfet,
    output pfm_meas_type meas
);
    // registered: a new sample never lands inside the tick's own step
    always_ff @(posedge ref_clk) begin
        meas <= '{stk, csum, vmax, vmin, cur, cur[15] ? 16'(-cur) : cur, tcell, tfet};
    end
endmodule

// ---- verification/tb_top.sv ----
// Purpose: directed checks of the permanent failure monitor
// Assumes: tick shortened to TC cycles
// Notes: trip windows allow for the unknown tick phase
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    import pfm_pkg::*;
    localparam int TC = 10;
    logic ref_clk = 0;
    logic nrst = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata;
    logic irq;
    logic [5:0] fl;
    logic [19:0] stk = 20'h09c40;
    logic [19:0] csum = 20'h09c40;
    logic [15:0] vmax = 16'h0bb8;
    logic [15:0] vmin = 16'h07d0;
    logic [15:0] cur = 16'h0000;
    logic [7:0] tcell = 8'h19;
    logic [7:0] tfet = 8'h19;
    pfm_meas_type meas;
    int errors = 0;
    int checks = 0;
    always #10 ref_clk = ~ref_clk;
    pfm_meas_src src (.ref_clk(ref_clk), .stk(stk), .csum(csum), .vmax(vmax), .vmin(vmin), .cur(cur),
        .tcell(tcell), .tfet(tfet), .meas(meas));
    pfm_monitor #(.TICK_CYCLES(TC)) dut (.ref_clk(ref_clk), .nrst(nrst), .meas(meas), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .stack_mismatch_fail_flag(fl[0]), .charge_overcurrent_fail(fl[1]), .discharge_overcurrent_fail(fl[2]),
        .cell_overtemp_fail(fl[3]), .fet_overtemp_fail(fl[4]), .imbalance_at_rest_fail(fl[5]));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // phase of the tick is unknown, so accept one tick of slack below
    task automatic trip(input int i, input int n_ticks);
        int n;
        n = 0;
        while (fl[i] !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n > (n_ticks - 1) * TC && n <= n_ticks * TC + 2, 1'b1)
    endtask
    task automatic t_chg();
        rd(ADDR_CELLS, 32'h10);
        rd(ADDR_DELAY_A, 32'h05050505);
        rd(ADDR_RELAX_DUR, 32'h64);
        rd(ADDR_RELAX_CNT, 32'h0);
        wr(ADDR_DSG_THR, 32'h7fff);
        wr(ADDR_INT_EN, 32'h3f);
        cur <= 16'h2710;
        repeat (3 * TC) @(posedge ref_clk);
        cur <= 16'h270f;
        repeat (2 * TC) @(posedge ref_clk);
        cur <= 16'h2710;
        trip(1, 5);
        `CHK(fl, 6'h02)
        @(posedge ref_clk);
        #1;
        `CHK(irq, 1'b1)
        rd(ADDR_INT_STAT, 32'h02);
        wr(ADDR_INT_CLR, 32'h02);
        `CHK(irq, 1'b0)
        cur <= 16'h0000;
        repeat (3 * TC) @(posedge ref_clk);
        `CHK(fl[1], 1'b1)
        $display("charge overcurrent test done");
    endtask
    task automatic t_dsg();
        wr(ADDR_INT_EN, 32'h0);
        cur <= 16'hffef;
        wr(ADDR_DSG_THR, 32'hfff0);
        wr(ADDR_DELAY_A, 32'h05050105);
        repeat (3 * TC) @(posedge ref_clk);
        `CHK(fl[2], 1'b0)
        cur <= 16'hfff0;
        trip(2, 1);
        `CHK(irq, 1'b0)
        wr(ADDR_INT_EN, 32'h04);
        `CHK(irq, 1'b1)
        wr(ADDR_INT_CLR, 32'h04);
        `CHK(irq, 1'b0)
        cur <= 16'h0000;
        $display("discharge overcurrent test done");
    endtask
    task automatic t_temp();
        wr(ADDR_TEMP_THR, 32'h1005);
        tcell <= 8'hfb;
        tfet <= 8'h0f;
        repeat (7 * TC) @(posedge ref_clk);
        `CHK(fl[4:3], 2'b00)
        tcell <= 8'h05;
        tfet <= 8'h96;
        trip(3, 5);
        `CHK(fl[4], 1'b1)
        $display("temperature test done");
    endtask
    task automatic t_stack();
        wr(ADDR_DELAY_B, 32'h0502);
        stk <= 20'h0bb80;
        cur <= 16'h0015;
        repeat (5 * TC) @(posedge ref_clk);
        `CHK(fl[0], 1'b0)
        wr(ADDR_CTRL, 32'h3e);
        cur <= 16'h0014;
        repeat (3 * TC) @(posedge ref_clk);
        `CHK(fl[0], 1'b0)
        rd(ADDR_CTRL, 32'h3e);
        wr(ADDR_CTRL, 32'h3f);
        trip(0, 2);
        stk <= 20'h09c40;
        $display("stack mismatch test done");
    endtask
    task automatic t_imb();
        wr(ADDR_RELAX_DUR, 32'h3);
        vmax <= 16'h0dab;
        cur <= 16'h0000;
        repeat (12 * TC) @(posedge ref_clk);
        `CHK(fl[5], 1'b0)
        vmax <= 16'h0e10;
        cur <= 16'h000a;
        repeat (12 * TC) @(posedge ref_clk);
        `CHK(fl[5], 1'b0)
        cur <= 16'h0000;
        trip(5, 8);
        rd(ADDR_FAIL, 32'h3f);
        $display("imbalance test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        t_chg();
        t_dsg();
        t_temp();
        t_stack();
        t_imb();
        tally_and_finish();
    end
    // whole run is well under 1500 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        tally_and_finish();
    end
endmodule
